/* File: logic/mbx_pkg.sv */
// Purpose: Shared constants and types of the slave reply handler
// Assumes: 100 MHz clock, register numbers are 16-bit data addresses
// Notes:   Settings arrive as plain ports from the drive's parameter store
`default_nettype none
package mbx_pkg;
  // Monitor register data addresses
  localparam logic [15:0] REG_FAULT_IN   = 16'h2129;
  localparam logic [15:0] REG_FAULT_OUT  = 16'h212a;
  localparam logic [15:0] REG_FAULT_STAT = 16'h212b;
  localparam logic [15:0] REG_USER_DISP  = 16'h2201;
  localparam logic [15:0] REG_AIN_V1     = 16'h2203;
  localparam logic [15:0] REG_AIN_I      = 16'h2204;
  localparam logic [15:0] REG_AIN_V2     = 16'h2205;
  localparam logic [15:0] REG_IGBT_TEMP  = 16'h2206;
  localparam logic [15:0] REG_SINK_TEMP  = 16'h2207;
  localparam logic [15:0] REG_DIN        = 16'h2208;
  localparam logic [15:0] REG_DOUT       = 16'h2209;
  // Writable command words and their reserved bits
  localparam logic [15:0] REG_CMD        = 16'h2000;
  localparam logic [15:0] REG_FREQ       = 16'h2001;
  localparam logic [15:0] REG_CTRL       = 16'h2002;
  localparam logic [15:0] CMD_RSVD_MASK  = 16'h8000;
  localparam logic [15:0] CTRL_RSVD_MASK = 16'hfff8;
  // Function and exception codes
  localparam logic [7:0]  FUNC_READ      = 8'h03;
  localparam logic [7:0]  FUNC_WRITE     = 8'h06;
  localparam logic [7:0]  FUNC_EXC_BIT   = 8'h80;
  localparam logic [7:0]  EXC_NONE       = 8'h00;
  localparam logic [7:0]  EXC_FUNC       = 8'h01;
  localparam logic [7:0]  EXC_ADDR       = 8'h02;
  localparam logic [7:0]  EXC_VALUE      = 8'h03;
  localparam logic [7:0]  EXC_BUSY       = 8'h04;
  localparam logic [15:0] READ_COUNT_ONE = 16'h0001;
  localparam logic [7:0]  READ_BYTES     = 8'h02;
  // Framing characters and check values
  localparam logic [7:0]  CH_COLON       = 8'h3a;
  localparam logic [7:0]  CH_CR          = 8'h0d;
  localparam logic [7:0]  CH_LF          = 8'h0a;
  localparam logic [7:0]  CH_ZERO        = 8'h30;
  localparam logic [7:0]  CH_A_MINUS_10  = 8'h37;
  localparam logic [15:0] CRC_INIT       = 16'hffff;
  localparam logic [15:0] CRC_POLY       = 16'ha001;
  // Timing: one tick is 0.1 ms, timeout unit is 0.1 s
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          TICK_TIME_NS   = 100000;
  localparam int          TICK_CYCLES    = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int          TOUT_UNIT_NS   = 100000000;
  localparam int          TICKS_PER_TOUT = TOUT_UNIT_NS / TICK_TIME_NS;
  localparam logic [11:0] REPLY_DELAY_DFLT = 12'h014;
  localparam logic [11:0] REPLY_DELAY_MAX  = 12'h7d0;
  localparam logic [2:0]  TREAT_TOUT_MAX   = 3'h1;
  // Sizes and reset values
  localparam int          FRAME_MAX      = 6;
  localparam int          FIFO_DEPTH     = 8;
  localparam int          BYTE_W         = 8;
  localparam logic [15:0] SNAP_RST       = 16'h0000;

  typedef struct packed {
    logic [7:0]  station;
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] value;
  } mbx_req_type;

  typedef struct packed {
    logic [15:0] user_disp;
    logic [15:0] ain_v1;
    logic [15:0] ain_i;
    logic [15:0] ain_v2;
    logic [15:0] igbt_temp;
    logic [15:0] sink_temp;
    logic [15:0] din;
    logic [15:0] dout;
  } mbx_mon_type;

  typedef struct packed {
    logic [15:0] drive_status;
    logic [15:0] in_terms;
    logic [15:0] out_terms;
  } mbx_snap_type;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_START = 4'b0001,
    ST_HI    = 4'b0010,
    ST_LO    = 4'b0011,
    ST_CHK0  = 4'b0100,
    ST_CHK1  = 4'b0101,
    ST_CR    = 4'b0110,
    ST_LF    = 4'b0111,
    ST_DONE  = 4'b1000
  } mbx_state_type;
endpackage : mbx_pkg
`default_nettype wire

/* File: logic/mbx_fifo.sv */
// Purpose: Byte FIFO between the frame builder and the transmitter
// Assumes: Source and sink share one clock
// Notes:   Full and empty come from a pointer pair with an extra wrap bit
`timescale 1ns/1ns
`default_nettype none
module mbx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;

  // Full when pointers differ only in the wrap bit
  assign in_ready  = (wr_ptr_r ^ rd_ptr_r) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr_r != rd_ptr_r;
  assign out_data  = mem_r[rd_ptr_r[AW-1:0]];

  // Storage write
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (in_valid && in_ready) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (out_valid && out_ready) rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule : mbx_fifo
`default_nettype wire

/* File: logic/mbx_check.sv */
// Purpose: Running CRC-16 and LRC over the raw reply bytes
// Assumes: One byte fed per enable, cleared before each frame
// Notes:   LRC is the two's complement of the byte sum
`timescale 1ns/1ns
`default_nettype none
module mbx_check (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Byte feed
  input  wire logic        clr,
  input  wire logic        en,
  input  wire logic [7:0]  din,
  // Results
  output logic [15:0]      crc,
  output logic [7:0]       lrc
);
  logic [7:0] sum_r;
  logic [15:0] crc_nxt;

  // Reflected polynomial, one bit per step, low bit first
  always_comb begin
    crc_nxt = crc ^ {8'h00, din};
    for (int i = 0; i < 8; i++) begin
      crc_nxt = crc_nxt[0] ? ((crc_nxt >> 1) ^ mbx_pkg::CRC_POLY)
                           : (crc_nxt >> 1);
    end
  end

  // Accumulators
  always_ff @(posedge clk) begin
    if (!rst_n || clr) begin
      crc   <= mbx_pkg::CRC_INIT;
      sum_r <= 8'h00;
    end else if (en) begin
      crc   <= crc_nxt;
      sum_r <= sum_r + din;
    end
  end

  assign lrc = 8'h00 - sum_r;
endmodule : mbx_check
`default_nettype wire

/* File: logic/mbx_slave.sv */
// Purpose: Decide reply, silence or exception and stream the reply frame
// Assumes: Upstream receiver checks framing, parity, LRC or CRC itself
// Notes:   Reply bytes wait in a FIFO until the reply delay has run out
//
// Behaviour
// - Frame failing communication checks is dropped with no reply at all.
// - Exception reply echoes function code with top bit set, then code.
// - Every exception shows its code in decimal on the keypad display.
// - ASCII: colon, hex address, function, code, LRC, CR LF; RTU: CRC.
// - Unsupported function code gives exception 01.
// - Unimplemented data address gives exception 02.
// - Unacceptable data value gives exception 03.
// - Valid request the drive cannot perform now gives exception 04.
// - Reply waits a programmable delay, 2.0 ms by default.
// - Fault latches drive status word into snapshot at 212BH.
// - Fault latches input terminal states into snapshot at 2129H.
// - Fault latches output terminal states into snapshot at 212AH.
// - Three analog inputs read as percentages at 2203H to 2205H.
// - Heatsink temperature at 2207H valid only on large models.
// - Function 03 reads exactly one parameter per request.
`timescale 1ns/1ns
`default_nettype none
module mbx_slave #(
  parameter int TICK_CYCLES = mbx_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Settings
  input  wire logic [7:0]           station_addr,
  input  wire logic                 ascii_mode,
  input  wire logic [7:0]           idle_timeout_period_setting,
  input  wire logic [2:0]           comm_fault_treatment_setting,
  input  wire logic [11:0]          reply_delay_setting,
  input  wire logic                 large_model,
  // Checked request from the receiver
  input  wire logic                 req_valid,
  input  wire logic                 req_ok,
  input  wire mbx_pkg::mbx_req_type req,
  input  wire logic                 rx_activity,
  output logic                      busy_r,
  // Drive core state
  input  wire logic                 drive_busy,
  input  wire logic                 fault_event,
  input  wire mbx_pkg::mbx_snap_type snap_live,
  input  wire mbx_pkg::mbx_mon_type mon,
  // Command write to the drive core
  output logic                      drv_wr_r,
  output logic [15:0]               drv_wr_addr_r,
  output logic [15:0]               drv_wr_data_r,
  // Reply byte stream
  output logic                      tx_valid_r,
  output logic [7:0]                tx_data_r,
  input  wire logic                 tx_ready,
  // Keypad indications
  input  wire logic                 exc_display_clear,
  output logic                      comm_exception_display_r,
  output logic [7:0]                comm_exception_code_r,
  output logic                      comm_timeout_display_r
);
  mbx_pkg::mbx_state_type state_r;
  mbx_pkg::mbx_snap_type  snap_r;
  logic [7:0]             frame_r [mbx_pkg::FRAME_MAX];
  logic [2:0]             last_r;
  logic [2:0]             idx_r;
  logic [24:0]            delay_cnt_r;
  logic [24:0]            delay_load;
  logic [11:0]            delay_set;
  logic [15:0]            pre_cnt_r;
  logic                   tick;
  logic [17:0]            idle_cnt_r;
  logic [17:0]            idle_limit;
  logic                   tout_en;
  logic                   load;
  logic [7:0]             exc_code;
  logic                   addr_ok;
  logic [15:0]            rd_data;
  logic [7:0]             cur;
  logic                   push_valid;
  logic                   push_ready;
  logic [7:0]             push_data;
  logic                   push_go;
  logic                   chk_en;
  logic [15:0]            crc;
  logic [7:0]             lrc;
  logic                   fifo_valid;
  logic                   fifo_ready;
  logic [7:0]             fifo_data;
  logic                   drain_ok;

  // Nibble to upper-case hex character
  function automatic logic [7:0] hex_ch(input logic [3:0] nib);
    hex_ch = (nib < 4'ha) ? (mbx_pkg::CH_ZERO + {4'h0, nib})
                          : (mbx_pkg::CH_A_MINUS_10 + {4'h0, nib});
  endfunction : hex_ch

  // Monitor read mux; unlisted addresses are not implemented
  always_comb begin
    addr_ok = 1'b1;
    rd_data = 16'h0000;
    case (req.addr)
      mbx_pkg::REG_FAULT_IN:   rd_data = snap_r.in_terms;
      mbx_pkg::REG_FAULT_OUT:  rd_data = snap_r.out_terms;
      mbx_pkg::REG_FAULT_STAT: rd_data = snap_r.drive_status;
      mbx_pkg::REG_USER_DISP:  rd_data = mon.user_disp;
      mbx_pkg::REG_AIN_V1:     rd_data = mon.ain_v1;
      mbx_pkg::REG_AIN_I:      rd_data = mon.ain_i;
      mbx_pkg::REG_AIN_V2:     rd_data = mon.ain_v2;
      mbx_pkg::REG_IGBT_TEMP:  rd_data = mon.igbt_temp;
      // Small models have no heatsink sensor, so zero is returned
      mbx_pkg::REG_SINK_TEMP:
        rd_data = large_model ? mon.sink_temp : 16'h0000;
      mbx_pkg::REG_DIN:        rd_data = mon.din;
      mbx_pkg::REG_DOUT:       rd_data = mon.dout;
      default:                 addr_ok = 1'b0;
    endcase
  end

  // Request judgement: first failing check names the exception
  always_comb begin
    exc_code = mbx_pkg::EXC_NONE;
    if (req.func == mbx_pkg::FUNC_READ) begin
      if (!addr_ok) begin
        exc_code = mbx_pkg::EXC_ADDR;
      end else if (req.value != mbx_pkg::READ_COUNT_ONE) begin
        exc_code = mbx_pkg::EXC_VALUE;
      end else if (drive_busy) begin
        exc_code = mbx_pkg::EXC_BUSY;
      end
    end else if (req.func == mbx_pkg::FUNC_WRITE) begin
      if (req.addr != mbx_pkg::REG_CMD && req.addr != mbx_pkg::REG_FREQ &&
          req.addr != mbx_pkg::REG_CTRL) begin
        exc_code = mbx_pkg::EXC_ADDR;
      end else if ((req.addr == mbx_pkg::REG_CMD &&
                    (req.value & mbx_pkg::CMD_RSVD_MASK) != 16'h0000) ||
                   (req.addr == mbx_pkg::REG_CTRL &&
                    (req.value & mbx_pkg::CTRL_RSVD_MASK) != 16'h0000)) begin
        exc_code = mbx_pkg::EXC_VALUE;
      end else if (drive_busy) begin
        exc_code = mbx_pkg::EXC_BUSY;
      end
    end else begin
      exc_code = mbx_pkg::EXC_FUNC;
    end
  end

  // Only checked frames for this station start a reply
  assign load = req_valid && !busy_r && req_ok &&
                req.station == station_addr;

  // Build the raw reply bytes at acceptance
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < mbx_pkg::FRAME_MAX; i++) frame_r[i] <= 8'h00;
      last_r <= 3'h0;
    end else if (load) begin
      frame_r[0] <= station_addr;
      if (exc_code != mbx_pkg::EXC_NONE) begin
        frame_r[1] <= req.func | mbx_pkg::FUNC_EXC_BIT;
        frame_r[2] <= exc_code;
        last_r     <= 3'h2;
      end else if (req.func == mbx_pkg::FUNC_READ) begin
        frame_r[1] <= req.func;
        frame_r[2] <= mbx_pkg::READ_BYTES;
        frame_r[3] <= rd_data[15:8];
        frame_r[4] <= rd_data[7:0];
        last_r     <= 3'h4;
      end else begin
        frame_r[1] <= req.func;
        frame_r[2] <= req.addr[15:8];
        frame_r[3] <= req.addr[7:0];
        frame_r[4] <= req.value[15:8];
        frame_r[5] <= req.value[7:0];
        last_r     <= 3'h5;
      end
    end
  end

  // Accepted command write is handed to the drive core
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drv_wr_r      <= 1'b0;
      drv_wr_addr_r <= 16'h0000;
      drv_wr_data_r <= 16'h0000;
    end else begin
      drv_wr_r <= load && exc_code == mbx_pkg::EXC_NONE &&
                  req.func == mbx_pkg::FUNC_WRITE;
      if (load) begin
        drv_wr_addr_r <= req.addr;
        drv_wr_data_r <= req.value;
      end
    end
  end

  // Keypad exception display; codes below ten read the same in decimal
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      comm_exception_display_r <= 1'b0;
      comm_exception_code_r    <= 8'h00;
    end else if (load && exc_code != mbx_pkg::EXC_NONE) begin
      comm_exception_display_r <= 1'b1;
      comm_exception_code_r    <= exc_code;
    end else if (exc_display_clear) begin
      comm_exception_display_r <= 1'b0;
    end
  end

  // Fault snapshots, read-only to the master
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      snap_r <= {3{mbx_pkg::SNAP_RST}};
    end else if (fault_event) begin
      snap_r <= snap_live;
    end
  end

  // Frame emitter
  assign cur        = frame_r[idx_r];
  assign push_valid = state_r != mbx_pkg::ST_IDLE &&
                      state_r != mbx_pkg::ST_DONE;
  assign push_go    = push_valid && push_ready;
  assign chk_en     = push_go && (ascii_mode ? state_r == mbx_pkg::ST_LO
                                             : state_r == mbx_pkg::ST_HI);

  // Character for the current step
  always_comb begin
    case (state_r)
      mbx_pkg::ST_START: push_data = mbx_pkg::CH_COLON;
      mbx_pkg::ST_HI:    push_data = ascii_mode ? hex_ch(cur[7:4]) : cur;
      mbx_pkg::ST_LO:    push_data = hex_ch(cur[3:0]);
      mbx_pkg::ST_CHK0:  push_data = ascii_mode ? hex_ch(lrc[7:4])
                                                : crc[7:0];
      mbx_pkg::ST_CHK1:  push_data = ascii_mode ? hex_ch(lrc[3:0])
                                                : crc[15:8];
      mbx_pkg::ST_CR:    push_data = mbx_pkg::CH_CR;
      mbx_pkg::ST_LF:    push_data = mbx_pkg::CH_LF;
      default:           push_data = 8'h00;
    endcase
  end

  // Emitter state; a full FIFO stalls every step
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= mbx_pkg::ST_IDLE;
      idx_r   <= 3'h0;
      busy_r  <= 1'b0;
    end else begin
      case (state_r)
        mbx_pkg::ST_IDLE: begin
          idx_r <= 3'h0;
          if (load) begin
            busy_r  <= 1'b1;
            state_r <= ascii_mode ? mbx_pkg::ST_START : mbx_pkg::ST_HI;
          end
        end
        mbx_pkg::ST_START: begin
          if (push_go) state_r <= mbx_pkg::ST_HI;
        end
        mbx_pkg::ST_HI: begin
          if (push_go) begin
            if (ascii_mode) begin
              state_r <= mbx_pkg::ST_LO;
            end else begin
              idx_r   <= idx_r + 3'h1;
              if (idx_r == last_r) state_r <= mbx_pkg::ST_CHK0;
            end
          end
        end
        mbx_pkg::ST_LO: begin
          if (push_go) begin
            idx_r   <= idx_r + 3'h1;
            state_r <= (idx_r == last_r) ? mbx_pkg::ST_CHK0 : mbx_pkg::ST_HI;
          end
        end
        mbx_pkg::ST_CHK0: begin
          if (push_go) state_r <= mbx_pkg::ST_CHK1;
        end
        mbx_pkg::ST_CHK1: begin
          if (push_go) begin
            state_r <= ascii_mode ? mbx_pkg::ST_CR : mbx_pkg::ST_DONE;
          end
        end
        mbx_pkg::ST_CR: begin
          if (push_go) state_r <= mbx_pkg::ST_LF;
        end
        mbx_pkg::ST_LF: begin
          if (push_go) state_r <= mbx_pkg::ST_DONE;
        end
        mbx_pkg::ST_DONE: begin
          // Stay busy until the last byte has left the output stage
          if (!fifo_valid && !tx_valid_r) begin
            state_r <= mbx_pkg::ST_IDLE;
            busy_r  <= 1'b0;
          end
        end
        default: begin
          state_r <= mbx_pkg::ST_IDLE;
          busy_r  <= 1'b0;
        end
      endcase
    end
  end

  // Check value is rebuilt for every reply
  mbx_check u_check (
    .clk   (clk),
    .rst_n (rst_n),
    .clr   (load),
    .en    (chk_en),
    .din   (cur),
    .crc   (crc),
    .lrc   (lrc)
  );

  // Reply buffer; lets the builder run ahead during the delay
  mbx_fifo #(
    .WIDTH (mbx_pkg::BYTE_W),
    .DEPTH (mbx_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );

  // Out-of-range delay settings fall back to the default
  assign delay_set  = (reply_delay_setting > mbx_pkg::REPLY_DELAY_MAX)
                      ? mbx_pkg::REPLY_DELAY_DFLT : reply_delay_setting;
  assign delay_load = 25'(delay_set * TICK_CYCLES);

  // Reply delay counted in cycles from acceptance
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      delay_cnt_r <= 25'h0;
    end else if (load) begin
      delay_cnt_r <= delay_load;
    end else if (delay_cnt_r != 25'h0) begin
      delay_cnt_r <= delay_cnt_r - 25'h1;
    end
  end

  assign drain_ok   = busy_r && delay_cnt_r == 25'h0;
  assign fifo_ready = drain_ok && (!tx_valid_r || tx_ready);

  // Output stage keeps every transmit port on a flop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_valid_r <= 1'b0;
      tx_data_r  <= 8'h00;
    end else if (!tx_valid_r || tx_ready) begin
      tx_valid_r <= fifo_valid && drain_ok;
      if (fifo_valid && drain_ok) tx_data_r <= fifo_data;
    end
  end

  // Free-running 0.1 ms prescaler for the idle watch
  assign tick = pre_cnt_r == 16'(TICK_CYCLES - 1);
  always_ff @(posedge clk) begin
    if (!rst_n || tick) begin
      pre_cnt_r <= 16'h0000;
    end else begin
      pre_cnt_r <= pre_cnt_r + 16'h0001;
    end
  end

  // Idle watch; resolution is one tick, so it may end up to 0.1 ms early
  assign tout_en    = idle_timeout_period_setting != 8'h00 &&
                      comm_fault_treatment_setting <= mbx_pkg::TREAT_TOUT_MAX;
  assign idle_limit = 18'(idle_timeout_period_setting *
                          mbx_pkg::TICKS_PER_TOUT);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idle_cnt_r             <= 18'h0;
      comm_timeout_display_r <= 1'b0;
    end else if (rx_activity || !tout_en) begin
      // New traffic clears the indication and restarts the watch
      idle_cnt_r             <= 18'h0;
      comm_timeout_display_r <= 1'b0;
    end else if (tick) begin
      if (idle_cnt_r >= idle_limit - 18'h1) begin
        comm_timeout_display_r <= 1'b1;
      end else begin
        idle_cnt_r <= idle_cnt_r + 18'h1;
      end
    end
  end
endmodule : mbx_slave
`default_nettype wire

/* File: tb/mbx_props.sv */
// Purpose: Port assertions of the reply handler
// Assumes: Bound into mbx_slave
// Notes:   Helper count runs while busy
`timescale 1ns/1ns
`default_nettype none
module mbx_props #(parameter int TICK_CYCLES = 10) (
  // Watched ports, grouped by width to keep the list short
  input wire logic clk, rst_n, ascii_mode, req_valid, req_ok, busy_r,
  input wire logic rx_activity, drive_busy, drv_wr_r, tx_valid_r, tx_ready,
  input wire logic comm_timeout_display_r,
  input wire logic [7:0] station_addr, idle_timeout_period_setting,
  input wire logic [7:0] tx_data_r,
  input wire logic [2:0] comm_fault_treatment_setting,
  input wire logic [11:0] reply_delay_setting,
  input wire logic [15:0] drv_wr_data_r, drv_wr_addr_r,
  input wire mbx_pkg::mbx_req_type req
);
  logic acc;
  logic first_r;
  int   cnt_r;
  assign acc = !busy_r && req_valid && req_ok && req.station == station_addr;
  // First byte after idle; cycles spent busy
  always_ff @(posedge clk) begin
    first_r <= !rst_n || !busy_r || (first_r && !(tx_valid_r && tx_ready));
    cnt_r <= (rst_n && busy_r) ? cnt_r + 1 : 0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_bad_drop: assert property (!busy_r && req_valid && !req_ok
    |=> !busy_r) else $error("bad frame taken");
  chk_idle_quiet: assert property (!busy_r |-> !tx_valid_r)
    else $error("byte while idle");
  chk_accept_busy: assert property (acc |=> busy_r)
    else $error("request not taken");
  chk_reply_delay: assert property (tx_valid_r
    && reply_delay_setting <= 12'h7d0
    |-> cnt_r >= reply_delay_setting * TICK_CYCLES) else $error("early");
  chk_first_byte: assert property (first_r && tx_valid_r
    && tx_ready |-> tx_data_r == (ascii_mode ? 8'h3a : station_addr))
    else $error("bad lead byte");
  chk_tx_hold: assert property (tx_valid_r && !tx_ready
    |=> tx_valid_r && $stable(tx_data_r)) else $error("byte dropped");
  chk_wr_pulse: assert property (acc && req.func == 8'h06
    && req.addr == 16'h2001 && !drive_busy |=> drv_wr_r
    && drv_wr_addr_r == 16'h2001 && drv_wr_data_r == $past(req.value))
    else $error("no write");
  chk_tmo_clear: assert property (rx_activity
    || idle_timeout_period_setting == 8'h00
    || comm_fault_treatment_setting > 3'h1 |=> !comm_timeout_display_r)
    else $error("timeout flag kept");
endmodule : mbx_props
`default_nettype wire

/* File: tb/mbx_master_model.sv */
// Purpose: Master side byte sink
// Assumes: Shares the slave clock
// Notes:   Slow mode takes every other cycle
`timescale 1ns/1ns
`default_nettype none
module mbx_master_model (
  // Clock, reset, pacing
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  // Reply stream
  input wire logic tx_valid_r,
  output logic     tx_ready,
  output logic     got
);
  logic ph_r;
  // Stall phase; a slow master exercises the hold of each byte
  always_ff @(posedge clk) ph_r <= rst_n && !ph_r;
  assign tx_ready = !slow || ph_r;
  assign got = tx_valid_r && tx_ready;
endmodule : mbx_master_model
`default_nettype wire

/* File: tb/mbx_slave_bench.sv */
// Purpose: Self-checking bench of the reply handler
// Assumes: Tick of 10 cycles
// Notes:   Xorshift data seeded with 20
`timescale 1ns/1ns
`default_nettype none
module mbx_slave_bench;
  logic clk = 1'b0, rst_n = 1'b0, asc = 1'b0, big = 1'b0, slow = 1'b0;
  logic rv = 1'b0, ok = 1'b1, act = 1'b0, dbusy = 1'b0, flt = 1'b0;
  logic busy_r, tmo, got, txv, rdy, disp;
  logic [7:0] idle = 8'h00, tx_data_r, code;
  logic [11:0] dly = 12'h000;
  logic [2:0] trt = 3'h0;
  logic [15:0] w;
  logic [31:0] seed = 32'h14;
  mbx_pkg::mbx_req_type req = '0;
  mbx_pkg::mbx_snap_type snap = '0;
  mbx_pkg::mbx_mon_type mon = '0;
  logic [7:0] rxq[$];
  int n_errors = 0, samples_checked = 0, k;
  mbx_slave #(.TICK_CYCLES(10)) uut (.clk, .rst_n, .station_addr(8'h01),
    .ascii_mode(asc), .idle_timeout_period_setting(idle),
    .comm_fault_treatment_setting(trt), .reply_delay_setting(dly),
    .large_model(big), .req_valid(rv), .req_ok(ok), .req, .rx_activity(act),
    .busy_r, .drive_busy(dbusy), .fault_event(flt), .snap_live(snap), .mon,
    .drv_wr_r(), .drv_wr_addr_r(), .drv_wr_data_r(), .tx_valid_r(txv),
    .tx_data_r, .tx_ready(rdy), .exc_display_clear(rv),
    .comm_exception_display_r(disp), .comm_exception_code_r(code),
    .comm_timeout_display_r(tmo));
  mbx_master_model host (.clk, .rst_n, .slow, .tx_valid_r(txv),
    .tx_ready(rdy), .got);
  always #5 clk = ~clk;
  // Every byte the master takes
  always @(posedge clk) if (got) rxq.push_back(tx_data_r);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [15:0] crc16(logic [7:0] b[$]);
    logic [15:0] c = 16'hffff;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction : crc16
  task automatic cmp(logic [15:0] g, e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic results();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic send(logic [7:0] f, logic [15:0] a, v, logic good);
    req = {8'h01, f, a, v};
    ok = good;
    rv = 1'b1;
    rxq = {};
    step(1);
    rv = 1'b0;
  endtask : send
  // Raw lists already hold their check bytes
  task automatic xfer(logic [7:0] f, logic [15:0] a, v, logic [7:0] e[$],
                      logic raw);
    logic [15:0] c;
    c = crc16(e);
    if (!raw) e = {e, c[7:0], c[15:8]};
    send(f, a, v, 1'b1);
    for (k = 0; k < 40000 && busy_r !== 1'b0; k++) step(1);
    if (busy_r !== 1'b0) begin
      n_errors++;
      results();
    end
    cmp(16'(rxq.size()), 16'(e.size()));
    foreach (e[i]) cmp({8'h00, rxq[i]}, {8'h00, e[i]});
    if (e[1][7]) cmp({8'h00, code}, {8'h00, e[2]});
    cmp(16'(disp), 16'(asc ? e[3] > 8'h37 : e[1][7]));
  endtask : xfer
  task automatic rd(logic [15:0] a, v);
    xfer(8'h03, a, 16'h0001, {8'h01, 8'h03, 8'h02, v[15:8], v[7:0]}, 1'b0);
  endtask : rd
  initial begin
    step(6);
    rst_n = 1'b1;
    mon = {rnd(), rnd(), rnd(), rnd()};
    snap = 48'({rnd(), rnd()});
    xfer(8'h06, 16'h3000, 16'h0001, {8'h01, 8'h86, 8'h02, 8'hc3, 8'ha1},
         1'b1);
    repeat (2) begin
      dly = 12'(rnd() & 32'h3);
      slow = ^rnd();
      w = 16'(rnd());
      xfer(8'h41, 16'h2203, 16'h0001, {8'h01, 8'hc1, 8'h01}, 1'b0);
      xfer(8'h03, 16'h2203, 16'h2, {8'h01, 8'h83, 8'h03}, 1'b0);
      xfer(8'h06, 16'h2002, 16'h0008, {8'h01, 8'h86, 8'h03}, 1'b0);
      dbusy = 1'b1;
      xfer(8'h03, 16'h2203, 16'h0001, {8'h01, 8'h83, 8'h04}, 1'b0);
      dbusy = 1'b0;
      xfer(8'h06, 16'h2001, w, {8'h01, 8'h06, 8'h20, 8'h01, w[15:8], w[7:0]},
           1'b0);
    end
    flt = 1'b1;
    step(1);
    flt = 1'b0;
    snap = ~snap;
    rd(16'h212b, ~snap.drive_status);
    rd(16'h2129, ~snap.in_terms);
    rd(16'h212a, ~snap.out_terms);
    rd(16'h2203, mon.ain_v1);
    rd(16'h2204, mon.ain_i);
    rd(16'h2205, mon.ain_v2);
    rd(16'h2207, 16'h0000);
    big = 1'b1;
    rd(16'h2207, mon.sink_temp);
    asc = 1'b1;
    xfer(8'h06, 16'h3000, 16'h0001, {8'h3a, 8'h30, 8'h31, 8'h38, 8'h36,
         8'h30, 8'h32, 8'h37, 8'h37, 8'h0d, 8'h0a}, 1'b1);
    send(8'h06, 16'h2001, 16'h0001, 1'b0);
    step(40);
    cmp(16'(rxq.size()), 16'h0000);
    idle = 8'h01;
    // Treatment above one keeps the idle watch off
    trt = 3'h2;
    step(10100);
    cmp({15'h0000, tmo}, 16'h0000);
    trt = 3'h1;
    for (k = 0; k < 11000 && tmo !== 1'b1; k++) step(1);
    cmp({15'h0000, k >= 9980 && k <= 10020}, 16'h0001);
    act = 1'b1;
    step(2);
    cmp({15'h0000, tmo}, 16'h0000);
    results();
  end
endmodule : mbx_slave_bench
bind mbx_slave mbx_props #(.TICK_CYCLES(TICK_CYCLES)) chk (.*);
`default_nettype wire
